// ### design/tdbhp_pkg.sv
package tdbhp_pkg;

	localparam int          SYNC_DEPTH     = 3;
	localparam int          BYTE_W         = 8;
	// released lines float high through the terminators
	localparam logic [7:0]  LINE_RELEASED  = 8'hFF;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;
	localparam logic        HS_INACTIVE    = 1'h1;
	localparam logic        HS_ACTIVE      = 1'h0;
	localparam logic [1:0]  CTRL_RESET     = 2'h3;

	typedef enum logic [2:0] {
		TDBHP_D_IDLE    = 3'h0,
		TDBHP_D_WAIT    = 3'h1,
		TDBHP_D_OFFER   = 3'h3,
		TDBHP_D_ACK     = 3'h2,
		TDBHP_D_RELEASE = 3'h6
	} tdbhp_drive_state_e;

	typedef enum logic [2:0] {
		TDBHP_H_IDLE    = 3'h0,
		TDBHP_H_SETUP   = 3'h1,
		TDBHP_H_STROBE  = 3'h3,
		TDBHP_H_RELEASE = 3'h2,
		TDBHP_H_TAKE    = 3'h6
	} tdbhp_host_state_e;

endpackage

// ### design/tdbhp_if.sv
`timescale 1ns/1ps
interface tdbhp_if;
	import tdbhp_pkg::*;

	logic [7:0] host_byte_out;
	logic       host_byte_oe;
	logic [7:0] drive_byte_out;
	logic       drive_byte_oe;
	logic [7:0] host_byte_line;
	logic       host_byte_strobe_n;
	logic       drive_byte_handshake_n;
	logic       drive_unit_ready_n;

	// bit 0 is host_byte_bit0 (lsb), bit 7 is host_byte_bit7 (msb)
	assign host_byte_line = host_byte_oe ? host_byte_out :
	                        drive_byte_oe ? drive_byte_out : LINE_RELEASED;

	modport drive (
		input  host_byte_line,
		input  host_byte_strobe_n,
		output drive_byte_out,
		output drive_byte_oe,
		output drive_byte_handshake_n,
		output drive_unit_ready_n
	);

	modport host (
		input  host_byte_line,
		input  drive_byte_handshake_n,
		input  drive_unit_ready_n,
		output host_byte_out,
		output host_byte_oe,
		output host_byte_strobe_n
	);

endinterface

// ### design/tdbhp_host.sv
`timescale 1ns/1ps
module tdbhp_host
	import tdbhp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	tdbhp_if.host           port,
	input  wire logic       mode_write,
	input  wire logic       mode_read,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            unit_ready
);

	logic [SYNC_DEPTH-1:0][9:0] sync;
	logic [9:0]                 pins;
	logic                       hs_low;
	tdbhp_host_state_e          state;
	logic [7:0]                 out_byte;
	logic                       strobe_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync <= '{default: 10'h3FF};
			pins <= 10'h3FF;
		end else begin
			sync <= {sync[SYNC_DEPTH-2:0],
			         {port.drive_unit_ready_n, port.drive_byte_handshake_n, port.host_byte_line}};
			for (int i = 0; i < 10; i++) begin
				if (sync[1][i] == sync[2][i]) begin
					pins[i] <= sync[2][i];
				end
			end
		end
	end

	assign unit_ready = ~pins[9];
	assign hs_low     = pins[8] == HS_ACTIVE;

	assign tx_ready = (state == TDBHP_H_IDLE) && mode_write && unit_ready && !hs_low;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= TDBHP_H_IDLE;
			out_byte <= BYTE_RESET;
			strobe_n <= HS_INACTIVE;
			rx_data  <= BYTE_RESET;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			case (state)
				TDBHP_H_IDLE: begin
					if (tx_ready && tx_valid) begin
						out_byte <= tx_data;
						state    <= TDBHP_H_SETUP;
					end else if (mode_read && unit_ready && hs_low) begin
						rx_data  <= ~pins[7:0];
						rx_valid <= 1'b1;
						strobe_n <= HS_ACTIVE;
						state    <= TDBHP_H_TAKE;
					end
				end
				TDBHP_H_SETUP: begin
					strobe_n <= HS_ACTIVE;
					state    <= TDBHP_H_STROBE;
				end
				TDBHP_H_STROBE: begin
					if (hs_low) begin
						strobe_n <= HS_INACTIVE;
						state    <= TDBHP_H_RELEASE;
					end
				end
				TDBHP_H_RELEASE: begin
					if (!hs_low) begin
						state <= TDBHP_H_IDLE;
					end
				end
				TDBHP_H_TAKE: begin
					if (!hs_low) begin
						strobe_n <= HS_INACTIVE;
						state    <= TDBHP_H_RELEASE;
					end
				end
				default: begin
					state    <= TDBHP_H_IDLE;
					strobe_n <= HS_INACTIVE;
				end
			endcase
		end
	end

	// lines driven only while a write byte is being offered
	assign port.host_byte_oe       = mode_write && (state != TDBHP_H_IDLE) && (state != TDBHP_H_TAKE);
	assign port.host_byte_out      = ~out_byte;
	assign port.host_byte_strobe_n = strobe_n;

endmodule

// ### design/tdbhp_drive.sv
`timescale 1ns/1ps
// Summary of operation
// - eight data lines, bit0 lsb, bit7 msb
// - drive outputs in read, inputs in write
// - data inverted: one is low level
// - host strobes when write byte is placed
// - host strobes when read byte is taken
// - first write strobe fall starts transfer
// - write: ready asserted once byte accepted
// - read: ready asserted once byte presented
// - unit ready needs power, cartridge, command readiness
module tdbhp_drive
	import tdbhp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	tdbhp_if.drive          port,
	input  wire logic       power_good,
	input  wire logic       cartridge_present,
	input  wire logic       command_ready,
	input  wire logic       mode_write,
	input  wire logic       mode_read,
	output logic [7:0]      wr_data,
	output logic            wr_valid,
	input  wire logic       wr_ready,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid,
	output logic            rd_ready,
	output logic            transfer_started
);

	logic [SYNC_DEPTH-1:0][8:0] sync;
	logic [8:0]                 pins;
	logic                       strobe_low;
	logic                       strobe_low_d;
	logic                       strobe_fall;
	logic                       unit_ready;
	logic                       write_on;
	logic                       read_on;
	tdbhp_drive_state_e         state;
	logic [7:0]                 out_byte;
	logic                       handshake_n;
	logic                       unit_ready_n;
	logic                       take_write;
	logic                       take_read;
	logic                       give_write;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync <= '{default: 9'h1FF};
			pins <= 9'h1FF;
		end else begin
			sync <= {sync[SYNC_DEPTH-2:0], {port.host_byte_strobe_n, port.host_byte_line}};
			for (int i = 0; i < 9; i++) begin
				if (sync[1][i] == sync[2][i]) begin
					pins[i] <= sync[2][i];
				end
			end
		end
	end

	assign strobe_low = pins[8] == HS_ACTIVE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_low_d <= 1'b0;
		end else begin
			strobe_low_d <= strobe_low;
		end
	end

	assign strobe_fall = strobe_low && !strobe_low_d;

	assign unit_ready = power_good && cartridge_present && command_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_ready_n <= HS_INACTIVE;
		end else begin
			unit_ready_n <= ~unit_ready;
		end
	end

	assign write_on = unit_ready && mode_write && !mode_read;
	assign read_on  = unit_ready && mode_read && !mode_write;

	// start flag: set by first strobe fall of a write command, set at once while in read mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_started <= 1'b0;
		end else if (write_on) begin
			if (strobe_fall) begin
				transfer_started <= 1'b1;
			end
		end else if (read_on) begin
			transfer_started <= 1'b1;
		end else begin
			transfer_started <= 1'b0;
		end
	end

	// a read byte is taken only while the strobe is released
	assign rd_ready   = read_on && (state == TDBHP_D_WAIT) && !strobe_low;
	assign take_write = write_on && (state == TDBHP_D_WAIT) && strobe_fall;
	assign take_read  = rd_ready && rd_valid;
	assign give_write = (state == TDBHP_D_OFFER) && wr_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_data  <= BYTE_RESET;
			wr_valid <= 1'b0;
		end else if (take_write) begin
			wr_data  <= ~pins[7:0];
			wr_valid <= 1'b1;
		end else if (give_write || (state != TDBHP_D_OFFER)) begin
			wr_valid <= 1'b0;
		end
	end

	// read byte reaches the lines one cycle ahead of the handshake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_byte <= BYTE_RESET;
		end else if (take_read) begin
			out_byte <= rd_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= TDBHP_D_IDLE;
		end else begin
			case (state)
				TDBHP_D_IDLE: begin
					if (write_on || read_on) begin
						state <= TDBHP_D_WAIT;
					end
				end
				TDBHP_D_WAIT: begin
					if (!write_on && !read_on) begin
						state <= TDBHP_D_IDLE;
					end else if (take_write) begin
						state <= TDBHP_D_OFFER;
					end else if (take_read) begin
						state <= TDBHP_D_ACK;
					end
				end
				TDBHP_D_OFFER: begin
					if (give_write) begin
						state <= TDBHP_D_RELEASE;
					end
				end
				TDBHP_D_ACK: begin
					if (!read_on) begin
						state <= TDBHP_D_IDLE;
					end else if (handshake_n == HS_ACTIVE && strobe_low) begin
						state <= TDBHP_D_RELEASE;
					end
				end
				TDBHP_D_RELEASE: begin
					if ((mode_write || mode_read) && !strobe_low) begin
						state <= TDBHP_D_WAIT;
					end else if (!write_on && !read_on) begin
						state <= TDBHP_D_IDLE;
					end
				end
				default: begin
					state <= TDBHP_D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			handshake_n <= HS_INACTIVE;
		end else begin
			case (state)
				TDBHP_D_OFFER: begin
					if (give_write) begin
						handshake_n <= HS_ACTIVE;
					end
				end
				TDBHP_D_ACK: begin
					if (!read_on) begin
						handshake_n <= HS_INACTIVE;
					end else if (handshake_n == HS_INACTIVE) begin
						handshake_n <= HS_ACTIVE;
					end else if (strobe_low) begin
						handshake_n <= HS_INACTIVE;
					end
				end
				TDBHP_D_RELEASE: begin
					if (!strobe_low) begin
						handshake_n <= HS_INACTIVE;
					end
				end
				default: begin
					handshake_n <= HS_INACTIVE;
				end
			endcase
		end
	end

	assign port.drive_byte_oe          = read_on;
	assign port.drive_byte_out         = ~out_byte;
	assign port.drive_byte_handshake_n = handshake_n;
	assign port.drive_unit_ready_n     = unit_ready_n;

endmodule

// ### verification/tdbhp_checker.sv
`timescale 1ns/1ps
module tdbhp_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] host_byte_out,
	input wire logic       host_byte_oe,
	input wire logic [7:0] drive_byte_out,
	input wire logic       drive_byte_oe,
	input wire logic       host_byte_strobe_n,
	input wire logic       drive_byte_handshake_n,
	input wire logic       drive_unit_ready_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_fall; $fell(host_byte_strobe_n) && host_byte_oe; endsequence
	sequence s_rd_fall; $fell(host_byte_strobe_n) && !host_byte_oe; endsequence
	sequence s_wr_ack; $fell(drive_byte_handshake_n) && !drive_byte_oe; endsequence
	property p_one_driver; !(host_byte_oe && drive_byte_oe); endproperty
	a_one_driver: assert property (p_one_driver) else $error("both ends drive");
	property p_setup; s_wr_fall |-> $past(host_byte_oe) && drive_byte_handshake_n; endproperty
	a_setup: assert property (p_setup) else $error("strobe without setup");
	property p_rd_ack; s_rd_fall |-> !drive_byte_handshake_n; endproperty
	a_rd_ack: assert property (p_rd_ack) else $error("read strobe unpaired");
	property p_rd_hold;
		!drive_byte_handshake_n && !$past(drive_byte_handshake_n) && drive_byte_oe |-> $stable(drive_byte_out);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
	property p_rd_setup; $fell(drive_byte_handshake_n) && drive_byte_oe |-> $stable(drive_byte_out); endproperty
	a_rd_setup: assert property (p_rd_setup) else $error("read byte not settled before ready");
	property p_wr_rel; $rose(drive_byte_handshake_n) && !drive_byte_oe |-> $past(host_byte_strobe_n, 2); endproperty
	a_wr_rel: assert property (p_wr_rel) else $error("write ready dropped early");
	property p_rd_rel; $rose(drive_byte_handshake_n) && drive_byte_oe |-> !$past(host_byte_strobe_n, 2); endproperty
	a_rd_rel: assert property (p_rd_rel) else $error("read ready dropped early");
	property p_unit; drive_unit_ready_n && $past(drive_unit_ready_n) |-> drive_byte_handshake_n; endproperty
	a_unit: assert property (p_unit) else $error("handshake while not ready");
	property p_wr_done; s_wr_ack |-> (!drive_byte_handshake_n)[*3] ##[1:20] $rose(host_byte_strobe_n); endproperty
	a_wr_done: assert property (p_wr_done) else $error("write exchange stuck");
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
	import tdbhp_pkg::*;
	logic       clk = 0, rst_n = 0, pg = 0, cart = 0, cmd = 0, mw = 0, mr = 0;
	logic       tx_valid = 0, wr_ready = 0, rd_valid = 0;
	logic [7:0] tx_data = 8'h00, rd_data = 8'h00, wr_data, rx_data;
	logic       tx_ready, rx_valid, unit_ready, wr_valid, rd_ready, started;
	logic [7:0] w [3] = '{8'h01, 8'h80, 8'hA5};
	logic [7:0] r [2] = '{8'h3C, 8'hC3};
	int         fail_count = 0, checks_done = 0, cyc = 0;
	tdbhp_if bus ();
	always #5 clk = ~clk;
	tdbhp_host i_tdbhp_host (.clk(clk), .rst_n(rst_n), .port(bus), .mode_write(mw), .mode_read(mr),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.unit_ready(unit_ready));
	tdbhp_drive i_tdbhp_drive (.clk(clk), .rst_n(rst_n), .port(bus), .power_good(pg), .cartridge_present(cart),
		.command_ready(cmd), .mode_write(mw), .mode_read(mr), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .transfer_started(started));
	tdbhp_checker i_tdbhp_checker (.clk(clk), .rst_n(rst_n), .host_byte_out(bus.host_byte_out),
		.host_byte_oe(bus.host_byte_oe), .drive_byte_out(bus.drive_byte_out), .drive_byte_oe(bus.drive_byte_oe),
		.host_byte_strobe_n(bus.host_byte_strobe_n), .drive_byte_handshake_n(bus.drive_byte_handshake_n),
		.drive_unit_ready_n(bus.drive_unit_ready_n));
	task chk(input string n, input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out;
		end
	end
	task t_unit;
		repeat (8) @(negedge clk);
		chk("unit", unit_ready, 0);
		@(posedge clk);
		pg <= 1;
		cmd <= 1;
		repeat (8) @(negedge clk);
		chk("unit_pin", bus.drive_unit_ready_n, 1);
		@(posedge clk);
		cart <= 1;
		cmd <= 0;
		repeat (8) @(negedge clk);
		chk("unit_cmd", bus.drive_unit_ready_n, 1);
		@(posedge clk);
		cmd <= 1;
		while (unit_ready !== 1'b1) @(negedge clk);
		chk("unit_pin", bus.drive_unit_ready_n, 0);
	endtask
	task t_write;
		@(posedge clk);
		mw <= 1;
		repeat (8) @(negedge clk);
		chk("started", started, 0);
		foreach (w[i]) begin
			while (tx_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
			tx_data <= w[i];
			tx_valid <= 1;
			@(posedge clk);
			tx_valid <= 0;
			while (bus.host_byte_strobe_n !== 1'b0) @(negedge clk);
			chk("line", bus.host_byte_line, ~w[i]);
			chk("tx_busy", tx_ready, 0);
			while (wr_valid !== 1'b1) @(negedge clk);
			chk("wr_data", wr_data, w[i]);
			chk("started", started, 1);
			repeat (3) @(negedge clk);
			chk("hs_held", bus.drive_byte_handshake_n, 1);
			@(posedge clk);
			wr_ready <= 1;
			while (bus.drive_byte_handshake_n !== 1'b0) @(negedge clk);
			chk("wr_valid", wr_valid, 0);
			@(posedge clk);
			wr_ready <= 0;
		end
		while (tx_ready !== 1'b1 || bus.drive_byte_handshake_n !== 1'b1) @(negedge clk);
	endtask
	task t_read;
		@(posedge clk);
		mw <= 0;
		mr <= 1;
		foreach (r[i]) begin
			while (bus.drive_byte_handshake_n !== 1'b1) @(negedge clk);
			@(posedge clk);
			rd_data <= r[i];
			rd_valid <= 1;
			while (rd_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
			rd_valid <= 0;
			while (bus.drive_byte_handshake_n !== 1'b0) @(negedge clk);
			chk("line", bus.host_byte_line, ~r[i]);
			chk("host_oe", bus.host_byte_oe, 0);
			chk("rd_busy", rd_ready, 0);
			while (rx_valid !== 1'b1) @(negedge clk);
			chk("rx_data", rx_data, r[i]);
		end
		while (bus.host_byte_strobe_n !== 1'b1 || bus.drive_byte_handshake_n !== 1'b1) @(negedge clk);
		@(posedge clk);
		mr <= 0;
		repeat (4) @(negedge clk);
		chk("released", bus.host_byte_line, 8'hFF);
		@(posedge clk);
		mw <= 1;
		mr <= 1;
		repeat (4) @(negedge clk);
		chk("both_started", started, 0);
		chk("both_line", bus.host_byte_line, 8'hFF);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		t_unit;
		t_write;
		t_read;
		close_out;
	end
endmodule
